// [cpm_pkg.sv]
// shared constants and types for the clock prescaler and power mode block
package cpm_pkg;
  localparam int PRESC_W = 13;
  localparam logic [12:0] PRESC_RST = 13'h0000;
  localparam int DIV_SEL_W = 3;
  localparam int WAIT_SEL_W = 3;
  localparam int TAP_SEL_W = 4;
  localparam int WAIT_CNT_W = 18;
  // least settle time in microseconds and the cycles it needs at 100 MHz
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 6500;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  // wait lengths in states selected by the standby wait field
  localparam logic [17:0] WAIT_0 = 18'h02000;
  localparam logic [17:0] WAIT_1 = 18'h04000;
  localparam logic [17:0] WAIT_2 = 18'h08000;
  localparam logic [17:0] WAIT_3 = 18'h10000;
  localparam logic [17:0] WAIT_4 = 18'h20000;
  localparam logic [17:0] WAIT_5 = 18'h00400;
  localparam logic [17:0] WAIT_6 = 18'h00080;
  localparam logic [17:0] WAIT_7 = 18'h00010;
  // one-hot operating modes
  typedef enum logic [4:0] {
    CPM_ACTIVE   = 5'h01,
    CPM_SLEEP    = 5'h02,
    CPM_STANDBY  = 5'h04,
    CPM_SUBSLEEP = 5'h08,
    CPM_WAKEWAIT = 5'h10
  } cpm_mode_e;
endpackage

// [cpm_presc_if.sv]
// prescaler link between the mode controller and the prescaler counter
`timescale 1ns/1ns
interface cpm_presc_if;
  logic tick;
  logic clear;
  logic [12:0] count;
  modport ctrl (output tick, output clear, input count);
  modport cnt (input tick, input clear, output count);
endinterface

// [cpm_presc.sv]
// 13-bit peripheral prescaler counter
`timescale 1ns/1ns
module cpm_presc
  import cpm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  cpm_presc_if.cnt bus
);
  logic [PRESC_W-1:0] count_r;
  logic [PRESC_W-1:0] count_nxt;

  // clear beats counting so standby always leaves zero
  assign count_nxt = bus.clear ? PRESC_RST :
                     (bus.tick ? count_r + 13'h0001 : count_r); // RL1
  assign bus.count = count_r;

  // count register, zero from reset
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) count_r <= PRESC_RST; // RL2
    else count_r <= count_nxt;
  end
endmodule // cpm_presc

// [cpm_clock_ctrl.sv]
// clock prescaler and power mode controller top
//
// Overview of operation
// RL1: prescaler is a 13-bit counter advancing once per system clock period.
// RL2: reset clears the prescaler; counting starts right after reset release.
// RL3: in standby or subsleep the clock stops and prescaler returns to zero.
// RL4: software has no read or write path to the prescaler count.
// RL5: prescaler offers divided clocks from clock/2 down to clock/8192.
// RL6: each peripheral picks its own division ratio independently.
// RL7: in active and sleep, prescaler input is clock divided by div select.
// RL8: five modes: active, sleep, standby, subsleep and module standby.
// RL9: active mode clocks the CPU and all peripherals.
// RL10: sleep mode halts the CPU, peripherals keep running.
// RL11: standby and subsleep halt CPU and peripherals; subsleep holds ports.
// RL12: each unused peripheral may be halted alone in module standby.
// RL13: sleep instruction enters sleep if standby select is 0, else standby.
// RL14: interrupt exit from standby waits a time chosen by wait select.
// RL15: separate clock enables for CPU and each peripheral module.
`timescale 1ns/1ns
module cpm_clock_ctrl
  import cpm_pkg::*;
#(
  parameter int NUM_MOD = 4,
  parameter logic [17:0] WAIT_SCALE = 18'h00001
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_sleep_req,
  input wire logic i_subsleep_req,
  input wire logic i_standby_select,
  input wire logic i_wake_irq,
  input wire logic [2:0] i_active_clock_div_sel,
  input wire logic [2:0] i_standby_wait_sel,
  input wire logic [NUM_MOD-1:0] i_mod_standby,
  input wire logic [NUM_MOD*TAP_SEL_W-1:0] i_mod_tap_sel,
  output logic o_cpu_clk_en,
  output logic [NUM_MOD-1:0] o_mod_clk_en,
  output logic [NUM_MOD-1:0] o_mod_tick,
  output logic o_clock_pulse_gen_run,
  output logic o_port_hold,
  output logic [4:0] o_mode
);
  // refuse shapes the logic cannot serve
  initial begin
    if (NUM_MOD < 1 || NUM_MOD > 32) begin
      $error("NUM_MOD must lie between 1 and 32");
    end
    if (WAIT_SCALE == 18'h00000) begin
      $error("WAIT_SCALE must be non-zero");
    end
  end

  // wait length in states for a given select code
  function automatic logic [17:0] wait_len(input logic [2:0] sel);
    case (sel)
      3'h0: wait_len = WAIT_0;
      3'h1: wait_len = WAIT_1;
      3'h2: wait_len = WAIT_2;
      3'h3: wait_len = WAIT_3;
      3'h4: wait_len = WAIT_4;
      3'h5: wait_len = WAIT_5;
      3'h6: wait_len = WAIT_6;
      default: wait_len = WAIT_7;
    endcase
  endfunction

  // rising-edge detect of one prescaler bit for tap 1..13
  function automatic logic tap_tick(input logic [12:0] cur,
                                    input logic [12:0] prev,
                                    input logic [3:0] sel);
    logic [3:0] idx;
    idx = (sel == 4'h0) ? 4'h0 : sel - 4'h1;
    if (sel == 4'h0 || sel > 4'hD) tap_tick = 1'b0;
    else tap_tick = cur[idx] & ~prev[idx];
  endfunction

  cpm_presc_if pif ();
  cpm_mode_e mode_r, mode_nxt;
  logic [2:0] div_cnt_r, div_cnt_nxt;
  logic [17:0] wait_r, wait_nxt;
  logic [12:0] prev_r;
  logic cpu_en_r, run_r, hold_r;
  logic [NUM_MOD-1:0] mod_en_r, tick_r;
  logic [NUM_MOD-1:0] mod_en_nxt, tick_nxt;
  logic halted, per_run, div_hit, wait_done;
  logic [2:0] div_lim;

  // the counter itself; no bus port reaches it
  cpm_presc u_presc (
    .i_ref_clk (i_ref_clk),
    .i_rst_b (i_rst_b),
    .bus (pif.cnt)
  ); // RL4

  // mode state decoding
  assign halted = (mode_r == CPM_STANDBY) || (mode_r == CPM_SUBSLEEP) ||
                  (mode_r == CPM_WAKEWAIT);
  assign per_run = (mode_r == CPM_ACTIVE) || (mode_r == CPM_SLEEP); // RL9
  assign wait_done = (wait_r == 18'h00000);

  // divide the system clock by 2^sel for sel 0..2 before the prescaler input; codes above 2 pass it undivided
  assign div_lim = (3'h1 << i_active_clock_div_sel[1:0]) - 3'h1;
  assign div_hit = (i_active_clock_div_sel == 3'h0) ||
                   (div_cnt_r >= div_lim) ||
                   (i_active_clock_div_sel > 3'h2); // RL7
  assign div_cnt_nxt = (halted || div_hit) ? 3'h0 : div_cnt_r + 3'h1;
  assign pif.tick = per_run & div_hit; // RL1 RL7
  assign pif.clear = halted; // RL3

  // mode transitions; sleep entry chooses by standby select
  always_comb begin
    mode_nxt = mode_r;
    wait_nxt = wait_r;
    case (mode_r)
      CPM_ACTIVE: begin
        if (i_subsleep_req) mode_nxt = CPM_SUBSLEEP;
        else if (i_sleep_req && i_standby_select)
          mode_nxt = CPM_STANDBY; // RL13
        else if (i_sleep_req) mode_nxt = CPM_SLEEP; // RL13
      end
      CPM_SLEEP: begin
        if (i_wake_irq) mode_nxt = CPM_ACTIVE; // RL10
      end
      CPM_STANDBY: begin
        if (i_wake_irq) begin
          mode_nxt = CPM_WAKEWAIT;
          wait_nxt = 18'(wait_len(i_standby_wait_sel) * WAIT_SCALE); // RL14
        end
      end
      CPM_SUBSLEEP: begin
        if (i_wake_irq) mode_nxt = CPM_ACTIVE; // RL11
      end
      CPM_WAKEWAIT: begin
        if (wait_done) mode_nxt = CPM_ACTIVE; // RL14
        else wait_nxt = wait_r - 18'h00001;
      end
      default: mode_nxt = CPM_ACTIVE;
    endcase
  end

  // per-module enables and independently chosen taps
  always_comb begin
    mod_en_nxt = '0;
    tick_nxt = '0;
    for (int m = 0; m < NUM_MOD; m++) begin
      mod_en_nxt[m] = per_run & ~i_mod_standby[m]; // RL12 RL15
      tick_nxt[m] = mod_en_nxt[m] &
        tap_tick(pif.count, prev_r,
                 i_mod_tap_sel[m*TAP_SEL_W +: TAP_SEL_W]); // RL5 RL6
    end
  end

  // state and counters
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_r <= CPM_ACTIVE; // RL2 RL8
      wait_r <= 18'h00000;
      div_cnt_r <= 3'h0;
      prev_r <= PRESC_RST;
    end else begin
      mode_r <= mode_nxt;
      wait_r <= wait_nxt;
      div_cnt_r <= div_cnt_nxt;
      prev_r <= pif.count;
    end
  end

  // registered outputs; cpu runs only in active mode
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cpu_en_r <= 1'b0;
      mod_en_r <= '0;
      tick_r <= '0;
      run_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      cpu_en_r <= (mode_nxt == CPM_ACTIVE); // RL9 RL10 RL15
      mod_en_r <= mod_en_nxt; // RL11
      tick_r <= tick_nxt;
      run_r <= ~halted; // RL3
      hold_r <= (mode_nxt == CPM_SUBSLEEP); // RL11
    end
  end

  assign o_cpu_clk_en = cpu_en_r;
  assign o_mod_clk_en = mod_en_r;
  assign o_mod_tick = tick_r;
  assign o_clock_pulse_gen_run = run_r;
  assign o_port_hold = hold_r;
  assign o_mode = mode_r;
endmodule // cpm_clock_ctrl

// [cpm_clock_ctrl_asserts.sv]
// port assertions for the clock prescaler and power mode controller
`timescale 1ns/1ns
module cpm_clock_ctrl_asserts
  import cpm_pkg::*;
#(
  parameter int NUM_MOD = 4,
  parameter logic [17:0] WAIT_SCALE = 18'h00001
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_sleep_req,
  input wire logic i_subsleep_req,
  input wire logic i_standby_select,
  input wire logic i_wake_irq,
  input wire logic [2:0] i_standby_wait_sel,
  input wire logic [NUM_MOD-1:0] i_mod_standby,
  input wire logic o_cpu_clk_en,
  input wire logic [NUM_MOD-1:0] o_mod_clk_en,
  input wire logic [NUM_MOD-1:0] o_mod_tick,
  input wire logic o_clock_pulse_gen_run,
  input wire logic o_port_hold,
  input wire logic [4:0] o_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire act = o_mode == 5'h01;
  wire go = act && i_sleep_req && !i_subsleep_req;
  // shortest wake wait: 16 states held, then active
  sequence s_wake;
    ##16 o_mode == 5'h10 ##1 act;
  endsequence
  // code 6, next shortest: 128 states held, then active
  sequence s_wake_long;
    ##128 o_mode == 5'h10 ##1 act;
  endsequence
  a_sleep_entry: assert property (go && !i_standby_select |=>
    o_mode == 5'h02)
    else $error("sleep entry wrong");
  a_standby_entry: assert property (go && i_standby_select |=>
    o_mode == 5'h04)
    else $error("standby entry wrong");
  a_subsleep_entry: assert property (act && i_subsleep_req |=>
    o_mode == 5'h08 && o_port_hold)
    else $error("subsleep entry wrong");
  a_sleep_cpu_halt: assert property (o_mode == 5'h02 |->
    !o_cpu_clk_en)
    else $error("cpu runs in sleep");
  a_sleep_mod_en: assert property ($past(o_mode) == 5'h02 &&
    o_mode == 5'h02 |-> o_mod_clk_en == ~$past(i_mod_standby))
    else $error("module enable wrong in sleep");
  a_standby_halt: assert property ($past(o_mode) == 5'h04 &&
    o_mode == 5'h04 |-> !o_clock_pulse_gen_run && o_mod_clk_en == '0 &&
    !o_cpu_clk_en)
    else $error("clocks run in standby");
  // the wait length was latched from the select seen one edge earlier
  a_wake_wait: assert property ($rose(o_mode == 5'h10) &&
    $past(i_standby_wait_sel) == 3'h7 && WAIT_SCALE == 18'h00001 |-> s_wake)
    else $error("wake wait length wrong");
  a_wake_wait_long: assert property ($rose(o_mode == 5'h10) &&
    $past(i_standby_wait_sel) == 3'h6 && WAIT_SCALE == 18'h00001 |->
    s_wake_long)
    else $error("long wake wait length wrong");
  a_active_run: assert property (act && $past(act) &&
    $past(i_rst_b) |-> o_cpu_clk_en && o_clock_pulse_gen_run)
    else $error("active mode not clocked");
  a_tick_pulse: assert property (o_mod_tick[0] |=>
    !o_mod_tick[0])
    else $error("tick longer than one cycle");
  a_subsleep_wake: assert property (o_mode == 5'h08 && i_wake_irq |=>
    act)
    else $error("subsleep wake wrong");
endmodule // cpm_clock_ctrl_asserts
bind cpm_clock_ctrl cpm_clock_ctrl_asserts
  #(.NUM_MOD(NUM_MOD), .WAIT_SCALE(WAIT_SCALE)) i_cpm_clock_ctrl_asserts (.*);

// [cpm_periph_model.sv]
// peripheral side model: measures the spacing of each module's ticks
`timescale 1ns/1ns
module cpm_periph_model #(parameter int N = 4) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [N-1:0] i_tick,
  output logic [N-1:0][15:0] o_period
);
  logic [N-1:0][15:0] age_r;
  // a tick latches the cycles seen since the previous one
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      age_r <= '0;
      o_period <= '0;
    end else begin
      for (int m = 0; m < N; m++) begin
        age_r[m] <= i_tick[m] ? 16'h0001 : age_r[m] + 16'h0001;
        if (i_tick[m]) o_period[m] <= age_r[m];
      end
    end
  end
endmodule // cpm_periph_model

// [cpm_clock_ctrl_tb.sv]
// self-checking bench for the clock prescaler and power mode block
`timescale 1ns/1ns
module cpm_clock_ctrl_tb;
  import cpm_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, slp = 1'b0, sub = 1'b0, sel = 1'b0;
  logic irq = 1'b0, cpu_en, run, hold;
  logic [2:0] div = 3'h0, wsel = 3'h7;
  logic [3:0] stb = 4'h0, mod_en, tick;
  logic [15:0] tap = 16'hD521;
  logic [4:0] mode, prev = 5'h01;
  logic [4:0] q[$];
  logic [3:0][15:0] period;
  logic [31:0] lfsr = 32'h38999FB0;
  logic [3:0] t;
  logic [4:0] want;
  int miscompares = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  cpm_clock_ctrl i_cpm_clock_ctrl (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_sleep_req(slp), .i_subsleep_req(sub), .i_standby_select(sel),
    .i_wake_irq(irq), .i_active_clock_div_sel(div), .i_standby_wait_sel(wsel),
    .i_mod_standby(stb), .i_mod_tap_sel(tap), .o_cpu_clk_en(cpu_en),
    .o_mod_clk_en(mod_en), .o_mod_tick(tick), .o_clock_pulse_gen_run(run),
    .o_port_hold(hold), .o_mode(mode));
  cpm_periph_model i_cpm_periph_model (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_tick(tick), .o_period(period));
  // next pseudo-random word of the stimulus source
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input string what, input logic [15:0] seen,
             input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits end 1 ns late so outputs have settled
  task go(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle request pulse launched on an edge
  task req(input int which);
    @(posedge clk);
    case (which)
      0: slp <= 1'b1;
      1: sub <= 1'b1;
      default: irq <= 1'b1;
    endcase
    @(posedge clk);
    slp <= 1'b0;
    sub <= 1'b0;
    irq <= 1'b0;
  endtask
  // watcher: each mode change takes the oldest queued note
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      miscompares++;
      final_report;
    end
    #1;
    if (rst_b && mode !== prev) begin
      prev = mode;
      // an unexpected change meets a code that no mode uses
      want = q.size() ? q.pop_front() : 5'h1F;
      check("mode", 16'(mode), 16'(want));
    end
  end
  initial begin
    // random taps for modules 1..3; module 0 keeps the shortest tap
    @(posedge clk);
    lfsr = lfsr_next(lfsr);
    tap <= {lfsr[11:0], 4'h1};
    wsel <= {2'h3, lfsr[12]};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    go(13000);
    // a tap outside 1..13 never ticks, so its period stays zero
    for (int m = 0; m < 4; m++) begin
      t = tap[m*4+:4];
      if (t == 4'h0 || t > 4'hD) check("no tick", period[m], 16'h0);
      else check("period", period[m], 16'h1 << t);
    end
    $display("tap test done");
    // divider codes stretch the shortest tap; codes above 2 give /1
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      div <= 3'(d);
      go(40);
      check("div period", period[0], d < 3 ? 16'h2 << d : 16'h2);
    end
    $display("divider test done");
    q.push_back(5'h02);
    req(0);
    lfsr = lfsr_next(lfsr);
    stb <= lfsr[3:0];
    go(4);
    check("cpu en", 16'(cpu_en), 16'h0);
    check("mod en", {12'h000, mod_en}, {12'h000, ~stb});
    q.push_back(5'h01);
    req(2);
    stb <= 4'h0;
    sel <= 1'b1;
    q.push_back(5'h04);
    req(0);
    go(4);
    check("run", 16'(run), 16'h0);
    q.push_back(5'h10);
    q.push_back(5'h01);
    req(2);
    // cpu stays halted for the whole wait, then runs one edge later
    go(int'(wsel == 3'h7 ? WAIT_7 : WAIT_6));
    check("cpu en", 16'(cpu_en), 16'h0);
    go(14);
    check("cpu en", 16'(cpu_en), 16'h1);
    q.push_back(5'h08);
    req(1);
    go(3);
    check("hold", 16'(hold), 16'h1);
    q.push_back(5'h01);
    req(2);
    req(2);
    go(3);
    check("queue", 16'(q.size()), 16'h0);
    check("hold", 16'(hold), 16'h0);
    check("run", 16'(run), 16'h1);
    $display("mode test done");
    final_report;
  end
endmodule // cpm_clock_ctrl_tb
